// ### src/tape_ctrl_map.svh
// Register locations, field positions and timing figures of the tape controller registers.
`ifndef TAPE_CTRL_MAP_SVH
`define TAPE_CTRL_MAP_SVH

`define REG_BUS_ADDR_LOW 2'h0
`define REG_CMD_POINTER 2'h1
`define REG_CTRL_STATUS 2'h2

`define DATA_W 16
`define ADDR_W 22
`define EXT_W 4
`define EXT_FIELD_LO 8
`define EXT_FIELD_HI 11
`define PTR_LOW_HI 15
`define PTR_LOW_LO 2
`define PTR_UPPER_HI 1
`define PTR_UPPER_LO 0
`define ADDR_UPPER_HI 17
`define ADDR_UPPER_LO 16
`define ADDR_EXT_LO 18
`define ADDR_EXT_HI 21

`define NXM_TIMEOUT_NS 20000
`define REF_CLK_PERIOD_NS 100
`define SYNC_BITS 2
`define SYNC_OFFLINE 0
`define SYNC_EXT_FEAT 1

`define TERM_CLASS_RESET 3'h0
`define FATAL_CLASS_RESET 2'h0

`endif

// ### src/tape_ctrl_pkg.sv
// Types shared by the tape controller register logic.
package tape_ctrl_pkg;
   typedef enum logic [2:0] {
      TC_NORMAL = 3'b000,
      TC_ATTENTION = 3'b001,
      TC_STATUS_ALERT = 3'b010,
      TC_FUNC_REJECT = 3'b011,
      TC_RECOV_MOVED = 3'b100,
      TC_RECOV_STILL = 3'b101,
      TC_UNRECOV_LOST = 3'b110,
      TC_FATAL = 3'b111
   } term_class_e;

   typedef enum logic [1:0] {
      FATAL_DIAG = 2'b00
   } fatal_class_e;

   typedef enum logic [2:0] {
      ST_INIT = 3'b000,
      ST_DIAG = 3'b001,
      ST_READY = 3'b010,
      ST_BUSY = 3'b011,
      ST_FATAL = 3'b100
   } ctrl_state_e;
endpackage

// ### src/dma_watch_if.sv
// Link between the register core and the bus response watchdog.
`timescale 1ns/1ps
interface dma_watch_if;
   logic req;
   logic reply;
   logic expired;
   modport watch (input req, input reply, output expired);
   modport core (output req, output reply, input expired);
endinterface

// ### src/pin_sync.sv
// Three-stage synchroniser for slow pin levels, changes only when stages two and three agree.
`timescale 1ns/1ps
module pin_sync #(
   parameter int W = 2
) (
   input wire logic i_ref_clk,
   input wire logic i_rst,
   input wire logic [W-1:0] i_d,
   output logic [W-1:0] o_q
);
   genvar g;
   generate
      for (g = 0; g < W; g = g + 1) begin : g_bit
         logic s1_reg;
         logic s2_reg;
         logic s3_reg;
         always_ff @(posedge i_ref_clk or posedge i_rst) begin
            if (i_rst) begin
               s1_reg <= 1'b0;
               s2_reg <= 1'b0;
               s3_reg <= 1'b0;
               o_q[g] <= 1'b0;
            end else begin
               s1_reg <= i_d[g];
               s2_reg <= s1_reg;
               s3_reg <= s2_reg;
               if (s2_reg == s3_reg) begin
                  o_q[g] <= s3_reg;
               end
            end
         end
      end
   endgenerate
endmodule

// ### src/dma_watchdog.sv
// Flags a memory cycle that gets no bus response within the allowed time.
`timescale 1ns/1ps
`include "tape_ctrl_map.svh"
module dma_watchdog (
   input wire logic i_ref_clk,
   input wire logic i_rst,
   dma_watch_if.watch w
);
   // Least wait rounds up to whole cycles.
   localparam int LIMIT = (`NXM_TIMEOUT_NS + `REF_CLK_PERIOD_NS - 1) / `REF_CLK_PERIOD_NS;
   localparam int CW = $clog2(LIMIT + 1);
   localparam logic [CW-1:0] LIMIT_C = CW'(LIMIT);
   localparam logic [CW-1:0] ONE_C = CW'(1);

   logic [CW-1:0] count_reg;
   logic fired_reg;
   wire waiting = w.req && !w.reply;
   wire hit = waiting && (count_reg == LIMIT_C - ONE_C);

   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         count_reg <= '0;
         fired_reg <= 1'b0;
      end else begin
         count_reg <= (waiting && !hit) ? count_reg + ONE_C : '0;
         fired_reg <= hit;
      end
   end

   assign w.expired = fired_reg;
endmodule

// ### src/tape_ctrl_host_registers.sv
// Host-visible address, command pointer and status registers of the tape controller.
`timescale 1ns/1ps
`include "tape_ctrl_map.svh"

////////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - Bus address low word reads at location zero.
// - Pointer word write loads bits 15-2, clears 1-0.
// - DMA progress keeps updating the bus address.
// - Bus initialize leaves bus address unchanged.
// - Written bits 1-0 become pointer bits 17-16.
// - Extension fills bits 21-18 unless features off.
// - Extension cleared after one use and initialize.
// - High status byte write loads the extension.
// - Pointer writes always acknowledged; refused when busy.
// - Accepted pointer write clears subsystem ready.
// - Maintenance pointer transfers refused with special condition.
// - Status word write triggers full hardware initialize.
// - Bit 15 flags error, exception, refusal, memory.
// - Bit 14 always reads zero.
// - RAM failure sets bit 13, inhibits message store.
// - No bus response in 20 us sets bit 11.
// - Bit 10 needs message address; others rejected.
// - Bits 9-8 mirror internal address bits 17-16.
// - Bit 7 ready; cleared by initialize, set after diagnostics.
// - Bit 6 offline, sampled only at completion.
// - Fatal class shown only with class seven.
// - Bits 3-1 carry the termination class.
// - Class seven is fatal controller error.
// - Extension write ignored when not ready; keeps ready.
module tape_ctrl_host_registers (
   input wire logic i_ref_clk,
   input wire logic i_rst,
   // Host register port.
   input wire logic i_bus_sel,
   input wire logic i_bus_write,
   input wire logic i_bus_byte,
   input wire logic i_bus_byte_high,
   input wire logic i_bus_maint,
   input wire logic [1:0] i_bus_index,
   input wire logic [`DATA_W-1:0] i_bus_wdata,
   input wire logic i_bus_init,
   output logic o_bus_ack,
   output logic [`DATA_W-1:0] o_bus_rdata,
   // Pins.
   input wire logic i_transport_offline,
   input wire logic i_ext_features,
   // Controller core side.
   input wire logic i_diag_pass,
   input wire logic i_diag_fail,
   input wire logic i_ram_fail,
   input wire logic i_dma_addr_valid,
   input wire logic [`ADDR_W-1:0] i_dma_addr,
   input wire logic i_dma_req,
   input wire logic i_dma_reply,
   input wire logic i_cmd_done,
   input wire logic [2:0] i_cmd_term_class,
   input wire logic i_cmd_exception,
   input wire logic i_cmd_write_char,
   input wire logic i_cmd_msg_addr_ok,
   output logic o_cmd_start,
   output logic [`ADDR_W-1:0] o_cmd_pointer,
   output logic o_hw_init,
   output logic o_dma_abort,
   output logic o_msg_store_inhibit
);

   ////////////////////////////////////////////////////////////////////////////////
   // Synchronised pins and watchdog.

   logic [`SYNC_BITS-1:0] pins_sync;
   dma_watch_if watch_link ();

   pin_sync #(
      .W(`SYNC_BITS)
   ) u_pin_sync (
      .i_ref_clk(i_ref_clk),
      .i_rst(i_rst),
      .i_d({i_ext_features, i_transport_offline}),
      .o_q(pins_sync)
   );

   assign watch_link.req = i_dma_req;
   assign watch_link.reply = i_dma_reply;

   dma_watchdog u_dma_watchdog (
      .i_ref_clk(i_ref_clk),
      .i_rst(i_rst),
      .w(watch_link.watch)
   );

   wire offline_now = pins_sync[`SYNC_OFFLINE];
   wire ext_enabled = pins_sync[`SYNC_EXT_FEAT];
   wire mem_timeout = watch_link.expired;

   ////////////////////////////////////////////////////////////////////////////////
   // State.

   tape_ctrl_pkg::ctrl_state_e state_reg;
   tape_ctrl_pkg::ctrl_state_e state_next;
   logic [`ADDR_W-1:0] bus_addr_reg;
   logic [`EXT_W-1:0] address_extension_reg;
   logic special_condition_reg;
   logic sanity_check_error_reg;
   logic modification_refused_reg;
   logic nonexistent_memory_reg;
   logic need_message_address_reg;
   logic transport_offline_reg;
   logic [1:0] fatal_class_reg;
   logic [2:0] termination_class_reg;

   ////////////////////////////////////////////////////////////////////////////////
   // Access decode.

   wire hit_addr = i_bus_sel && (i_bus_index == `REG_BUS_ADDR_LOW);
   wire hit_ptr = i_bus_sel && (i_bus_index == `REG_CMD_POINTER);
   wire hit_stat = i_bus_sel && (i_bus_index == `REG_CTRL_STATUS);
   wire hit_read = i_bus_sel && !i_bus_write;
   wire subsystem_ready = (state_reg == tape_ctrl_pkg::ST_READY);

   wire ptr_write = hit_ptr && i_bus_write;
   wire ptr_normal = ptr_write && !i_bus_byte && !i_bus_maint;
   wire ptr_accept = ptr_normal && subsystem_ready;
   wire ptr_refuse = ptr_write && (i_bus_maint || (!i_bus_byte && !subsystem_ready));

   wire stat_word_write = hit_stat && i_bus_write && !i_bus_byte;
   wire ext_write = hit_stat && i_bus_write && i_bus_byte && i_bus_byte_high;
   wire ext_load = ext_write && subsystem_ready;

   wire init_now = i_bus_init || stat_word_write;

   ////////////////////////////////////////////////////////////////////////////////
   // Command pointer assembly.

   logic [`ADDR_W-1:0] pointer_value;
   wire [`EXT_W-1:0] ext_used = ext_enabled ? address_extension_reg : '0;
   always_comb begin
      pointer_value = '0;
      pointer_value[`PTR_LOW_HI:`PTR_LOW_LO] = i_bus_wdata[`PTR_LOW_HI:`PTR_LOW_LO];
      pointer_value[`ADDR_UPPER_HI:`ADDR_UPPER_LO] =
         i_bus_wdata[`PTR_UPPER_HI:`PTR_UPPER_LO];
      pointer_value[`ADDR_EXT_HI:`ADDR_EXT_LO] = ext_used;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Command completion decode.

   wire reject_for_nba = need_message_address_reg && !i_cmd_write_char;
   wire [2:0] done_class = reject_for_nba ? tape_ctrl_pkg::TC_FUNC_REJECT : i_cmd_term_class;
   wire done_special = i_cmd_exception || reject_for_nba || (done_class != 3'h0);
   wire cmd_finish = i_cmd_done && (state_reg == tape_ctrl_pkg::ST_BUSY);

   ////////////////////////////////////////////////////////////////////////////////
   // Controller sequence.

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         tape_ctrl_pkg::ST_INIT: begin
            state_next = tape_ctrl_pkg::ST_DIAG;
         end
         tape_ctrl_pkg::ST_DIAG: begin
            if (i_diag_fail) begin
               state_next = tape_ctrl_pkg::ST_FATAL;
            end else if (i_diag_pass) begin
               state_next = tape_ctrl_pkg::ST_READY;
            end
         end
         tape_ctrl_pkg::ST_READY: begin
            if (ptr_accept) begin
               state_next = tape_ctrl_pkg::ST_BUSY;
            end
         end
         tape_ctrl_pkg::ST_BUSY: begin
            if (i_cmd_done) begin
               state_next = tape_ctrl_pkg::ST_READY;
            end
         end
         tape_ctrl_pkg::ST_FATAL: begin
            state_next = tape_ctrl_pkg::ST_FATAL;
         end
         default: begin
            state_next = tape_ctrl_pkg::ST_INIT;
         end
      endcase
      if (init_now) begin
         state_next = tape_ctrl_pkg::ST_INIT;
      end
   end

   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         state_reg <= tape_ctrl_pkg::ST_INIT;
      end else begin
         state_reg <= state_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Internal bus address. Initialize deliberately does not touch it.

   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         bus_addr_reg <= '0;
      end else if (ptr_accept && !init_now) begin
         bus_addr_reg <= pointer_value;
      end else if (i_dma_addr_valid) begin
         bus_addr_reg <= i_dma_addr;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Address extension.

   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         address_extension_reg <= '0;
      end else if (init_now || ptr_accept) begin
         address_extension_reg <= '0;
      end else if (ext_load) begin
         address_extension_reg <= i_bus_wdata[`EXT_FIELD_HI:`EXT_FIELD_LO];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Status flags. Clears come first so that a same-cycle event other than command completion still sets its flag.

   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         special_condition_reg <= 1'b0;
         sanity_check_error_reg <= 1'b0;
         modification_refused_reg <= 1'b0;
         nonexistent_memory_reg <= 1'b0;
         need_message_address_reg <= 1'b1;
         termination_class_reg <= `TERM_CLASS_RESET;
         fatal_class_reg <= `FATAL_CLASS_RESET;
      end else begin
         if (init_now) begin
            special_condition_reg <= 1'b0;
            sanity_check_error_reg <= 1'b0;
            modification_refused_reg <= 1'b0;
            nonexistent_memory_reg <= 1'b0;
            need_message_address_reg <= 1'b1;
            termination_class_reg <= `TERM_CLASS_RESET;
            fatal_class_reg <= `FATAL_CLASS_RESET;
         end else if (ptr_accept) begin
            special_condition_reg <= 1'b0;
            modification_refused_reg <= 1'b0;
            nonexistent_memory_reg <= 1'b0;
            termination_class_reg <= tape_ctrl_pkg::TC_NORMAL;
         end
         if (cmd_finish && !init_now) begin
            termination_class_reg <= done_class;
            if (done_special) begin
               special_condition_reg <= 1'b1;
            end
            if (i_cmd_write_char && i_cmd_msg_addr_ok) begin
               need_message_address_reg <= 1'b0;
            end
         end
         if (ptr_refuse) begin
            modification_refused_reg <= 1'b1;
            special_condition_reg <= 1'b1;
         end
         if (mem_timeout) begin
            nonexistent_memory_reg <= 1'b1;
            special_condition_reg <= 1'b1;
         end
         if (i_ram_fail) begin
            sanity_check_error_reg <= 1'b1;
         end
         if (i_diag_fail && state_reg == tape_ctrl_pkg::ST_DIAG) begin
            special_condition_reg <= 1'b1;
            termination_class_reg <= tape_ctrl_pkg::TC_FATAL;
            fatal_class_reg <= tape_ctrl_pkg::FATAL_DIAG;
         end
      end
   end

   // Offline is a snapshot taken when a command completes.
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         transport_offline_reg <= 1'b0;
      end else if (cmd_finish) begin
         transport_offline_reg <= offline_now;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Read data.

   wire fatal_visible = special_condition_reg &&
      (termination_class_reg == tape_ctrl_pkg::TC_FATAL);
   wire [1:0] fatal_shown = fatal_visible ? fatal_class_reg : 2'h0;

   wire [`DATA_W-1:0] status_word = {
      special_condition_reg,
      1'b0,
      sanity_check_error_reg,
      modification_refused_reg,
      nonexistent_memory_reg,
      need_message_address_reg,
      bus_addr_reg[`ADDR_UPPER_HI:`ADDR_UPPER_LO],
      subsystem_ready,
      transport_offline_reg,
      fatal_shown,
      termination_class_reg,
      1'b0
   };

   logic [`DATA_W-1:0] read_mux;
   always_comb begin
      if (hit_addr) begin
         read_mux = bus_addr_reg[`DATA_W-1:0];
      end else if (hit_stat) begin
         read_mux = status_word;
      end else begin
         read_mux = '0;
      end
   end

   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         o_bus_rdata <= '0;
         o_bus_ack <= 1'b0;
      end else begin
         o_bus_ack <= i_bus_sel;
         if (hit_read) begin
            o_bus_rdata <= read_mux;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Core-facing outputs.

   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         o_cmd_start <= 1'b0;
         o_cmd_pointer <= '0;
         o_hw_init <= 1'b0;
         o_dma_abort <= 1'b0;
         o_msg_store_inhibit <= 1'b0;
      end else begin
         o_cmd_start <= ptr_accept && !init_now;
         if (ptr_accept) begin
            o_cmd_pointer <= pointer_value;
         end
         o_hw_init <= init_now;
         o_dma_abort <= mem_timeout;
         if (init_now) begin
            o_msg_store_inhibit <= 1'b0;
         end
         if (i_ram_fail) begin
            o_msg_store_inhibit <= 1'b1;
         end
      end
   end

endmodule

// ### test/host_bus_model.sv
// Host processor model that issues register cycles to the tape controller.
`timescale 1ns/1ps
module host_bus_model (
   input wire logic i_ref_clk,
   input wire logic i_bus_ack,
   input wire logic [15:0] i_bus_rdata,
   output logic o_sel,
   output logic o_write,
   output logic o_byte,
   output logic o_high,
   output logic o_maint,
   output logic [1:0] o_index,
   output logic [15:0] o_wdata
);
   initial begin
      {o_sel, o_write, o_byte, o_high, o_maint, o_index, o_wdata} = '0;
   end
   ////////////////////////////////////////
   // One access: select for one cycle, take ack and data one cycle later.
   task automatic cycle(input logic w, b, h, m, input logic [1:0] i, input logic [15:0] d,
                        output logic a, output logic [15:0] r);
      @(posedge i_ref_clk);
      {o_sel, o_write, o_byte, o_high, o_maint, o_index, o_wdata} <= {1'b1, w, b, h, m, i, d};
      @(posedge i_ref_clk);
      o_sel <= 1'b0;
      // A released data bus must not keep showing the last value.
      o_wdata <= ~d;
      // Ack and read data stand in the cycle after the taking edge.
      @(posedge i_ref_clk);
      a = i_bus_ack;
      r = i_bus_rdata;
   endtask
   // The extension is loaded only by a high-byte write, before every pointer that needs it.
   task automatic ext_load(input logic [3:0] ext);
      logic a;
      logic [15:0] r;
      cycle(1'b1, 1'b1, 1'b1, 1'b0, 2'h2, {4'h0, ext, 8'h00}, a, r);
   endtask
endmodule

// ### test/tape_ctrl_host_registers_monitor.sv
// Concurrent checks on the ports of the tape controller register block.
`timescale 1ns/1ps
`include "tape_ctrl_map.svh"
module tape_ctrl_host_registers_monitor (
   input wire logic i_ref_clk,
   input wire logic i_rst,
   input wire logic i_bus_sel,
   input wire logic i_bus_write,
   input wire logic i_bus_byte,
   input wire logic i_bus_maint,
   input wire logic [1:0] i_bus_index,
   input wire logic [`DATA_W-1:0] i_bus_wdata,
   input wire logic i_bus_init,
   input wire logic o_bus_ack,
   input wire logic [`DATA_W-1:0] o_bus_rdata,
   input wire logic i_ram_fail,
   input wire logic i_dma_req,
   input wire logic i_dma_reply,
   input wire logic o_cmd_start,
   input wire logic [`ADDR_W-1:0] o_cmd_pointer,
   input wire logic o_hw_init,
   input wire logic o_dma_abort,
   input wire logic o_msg_store_inhibit
);
   logic [7:0] stall_cnt;
   wire word_wr = i_bus_sel && i_bus_write && !i_bus_byte;
   wire ptr_ok = word_wr && !i_bus_maint && i_bus_index == 2'h1;
   wire stat_wr = word_wr && i_bus_index == 2'h2;
   wire stat_rd = i_bus_sel && !i_bus_write && i_bus_index == 2'h2;
   wire stalled = i_dma_req && !i_dma_reply;
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         stall_cnt <= 8'h00;
      end else begin
         stall_cnt <= !stalled ? 8'h00 : (stall_cnt == 8'hff ? stall_cnt : stall_cnt + 8'h01);
      end
   end
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (i_rst);
   ////////////////////////////////////////
   chk_ack_follows_sel: assert property (i_bus_sel |=> o_bus_ack)
      else $error("access not acknowledged");
   chk_ack_has_cause: assert property (o_bus_ack |-> $past(i_bus_sel))
      else $error("ack without access");
   chk_status_zero_bits: assert property (stat_rd |=> !o_bus_rdata[14] && !o_bus_rdata[0])
      else $error("status reserved bit not zero");
   chk_pointer_bit_map: assert property (o_cmd_start |-> o_cmd_pointer[17:0] ==
      {$past(i_bus_wdata[1:0]), $past(i_bus_wdata[15:2]), 2'b00})
      else $error("pointer bits misplaced");
   chk_start_from_write: assert property (o_cmd_start |-> $past(ptr_ok))
      else $error("start without plain pointer word write");
   chk_init_from_cause: assert property ((stat_wr && !i_bus_maint) || i_bus_init |=> o_hw_init)
      else $error("init missing after status write");
   chk_init_has_cause: assert property (o_hw_init |-> $past(stat_wr) || $past(i_bus_init))
      else $error("init without cause");
   chk_ram_fail_inhibit: assert property (i_ram_fail |=> o_msg_store_inhibit)
      else $error("message store not inhibited");
   chk_abort_after_stall: assert property (o_dma_abort |-> $past(stall_cnt) >= 8'hbe)
      else $error("memory abort too early");
   cov_start: cover property (o_cmd_start);
   cov_init: cover property (o_hw_init);
   cov_abort: cover property (o_dma_abort);
endmodule
bind tape_ctrl_host_registers tape_ctrl_host_registers_monitor i_mon (
   .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_bus_sel(i_bus_sel), .i_bus_write(i_bus_write),
   .i_bus_byte(i_bus_byte), .i_bus_maint(i_bus_maint), .i_bus_index(i_bus_index),
   .i_bus_wdata(i_bus_wdata), .i_bus_init(i_bus_init), .o_bus_ack(o_bus_ack),
   .o_bus_rdata(o_bus_rdata), .i_ram_fail(i_ram_fail), .i_dma_req(i_dma_req),
   .i_dma_reply(i_dma_reply), .o_cmd_start(o_cmd_start), .o_cmd_pointer(o_cmd_pointer),
   .o_hw_init(o_hw_init), .o_dma_abort(o_dma_abort), .o_msg_store_inhibit(o_msg_store_inhibit));

// ### test/tape_ctrl_host_registers_tb.sv
// Self-checking bench for the tape controller host registers.
`timescale 1ns/1ps
module tape_ctrl_host_registers_tb;
   logic ref_clk, rst, sel, wr, bt, hi, mt, bus_init, offline, ext_feat;
   logic diag_pass, diag_fail, ram_fail, addr_valid, dma_req, dma_reply, done, wchar, ma_ok, exc;
   logic ack, cmd_start, hw_init, dma_abort, inhibit;
   logic [1:0] idx;
   logic [2:0] tc;
   logic [15:0] wd, rdata;
   logic [21:0] dma_addr, cmd_ptr;
   int n_mismatch = 0;
   int compares = 0;
   int n;
   tape_ctrl_host_registers i_dut (.i_ref_clk(ref_clk), .i_rst(rst), .i_bus_sel(sel),
      .i_bus_write(wr), .i_bus_byte(bt), .i_bus_byte_high(hi), .i_bus_maint(mt),
      .i_bus_index(idx), .i_bus_wdata(wd), .i_bus_init(bus_init), .o_bus_ack(ack),
      .o_bus_rdata(rdata), .i_transport_offline(offline), .i_ext_features(ext_feat),
      .i_diag_pass(diag_pass), .i_diag_fail(diag_fail), .i_ram_fail(ram_fail),
      .i_dma_addr_valid(addr_valid), .i_dma_addr(dma_addr), .i_dma_req(dma_req),
      .i_dma_reply(dma_reply), .i_cmd_done(done), .i_cmd_term_class(tc),
      .i_cmd_exception(exc), .i_cmd_write_char(wchar), .i_cmd_msg_addr_ok(ma_ok),
      .o_cmd_start(cmd_start), .o_cmd_pointer(cmd_ptr), .o_hw_init(hw_init),
      .o_dma_abort(dma_abort), .o_msg_store_inhibit(inhibit));
   host_bus_model i_host (.i_ref_clk(ref_clk), .i_bus_ack(ack), .i_bus_rdata(rdata),
      .o_sel(sel), .o_write(wr), .o_byte(bt), .o_high(hi), .o_maint(mt), .o_index(idx),
      .o_wdata(wd));
   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end
   ////////////////////////////////////////
   task automatic chk(input string what, input logic [21:0] seen, input logic [21:0] exp);
      compares++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask
   task automatic bit_chk(input string what, input logic seen, input logic exp);
      chk(what, {21'h0, seen}, {21'h0, exp});
   endtask
   task automatic give_verdict();
      $display("comparisons %0d, mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic acc(input logic m, input logic [1:0] i, input logic [15:0] d);
      logic a;
      logic [15:0] r;
      i_host.cycle(1'b1, 1'b0, 1'b0, m, i, d, a, r);
      bit_chk("write ack", a, 1'b1);
   endtask
   task automatic rd(input logic [1:0] i, input logic [15:0] mask, input logic [15:0] exp);
      logic a;
      logic [15:0] r;
      i_host.cycle(1'b0, 1'b0, 1'b0, 1'b0, i, 16'h0000, a, r);
      bit_chk("read ack", a, 1'b1);
      chk($sformatf("register %0d", i), {6'h00, r & mask}, {6'h00, exp});
   endtask
   // Diagnostics report a few cycles after init, then ready settles.
   task automatic boot(input logic fail);
      repeat (3) @(posedge ref_clk);
      diag_pass <= !fail;
      diag_fail <= fail;
      @(posedge ref_clk);
      diag_pass <= 1'b0;
      diag_fail <= 1'b0;
      repeat (2) @(posedge ref_clk);
   endtask
   ////////////////////////////////////////
   task automatic t_pointer();
      boot(1'b0);
      rd(2'h2, 16'hffff, 16'h0480);
      rd(2'h3, 16'hffff, 16'h0000);
      i_host.ext_load(4'ha);
      rd(2'h2, 16'hffff, 16'h0480);
      acc(1'b0, 2'h1, 16'h1237);
      bit_chk("start", cmd_start, 1'b1);
      chk("pointer", cmd_ptr, 22'h2b1234);
      rd(2'h2, 16'hffff, 16'h0700);
      rd(2'h0, 16'hffff, 16'h1234);
      @(posedge ref_clk);
      bus_init <= 1'b1;
      @(posedge ref_clk);
      bus_init <= 1'b0;
      #1;
      bit_chk("bus init", hw_init, 1'b1);
      rd(2'h0, 16'hffff, 16'h1234);
      boot(1'b0);
      rd(2'h2, 16'hffff, 16'h0780);
      acc(1'b0, 2'h1, 16'h0004);
      chk("pointer", cmd_ptr, 22'h000004);
      $display("test pointer done");
   endtask
   task automatic t_refused();
      acc(1'b0, 2'h1, 16'h0008);
      bit_chk("start", cmd_start, 1'b0);
      rd(2'h2, 16'hffff, 16'h9400);
      acc(1'b0, 2'h2, 16'h0000);
      bit_chk("status init", hw_init, 1'b1);
      rd(2'h2, 16'hffff, 16'h0400);
      boot(1'b0);
      acc(1'b1, 2'h1, 16'h0010);
      bit_chk("start", cmd_start, 1'b0);
      rd(2'h2, 16'hffff, 16'h9480);
      acc(1'b0, 2'h1, 16'h0000);
      bit_chk("start", cmd_start, 1'b1);
      rd(2'h2, 16'hffff, 16'h0400);
      $display("test refused done");
   endtask
   task automatic t_complete();
      @(posedge ref_clk);
      offline <= 1'b1;
      tc <= 3'h5;
      wchar <= 1'b1;
      ma_ok <= 1'b1;
      repeat (5) @(posedge ref_clk);
      done <= 1'b1;
      @(posedge ref_clk);
      done <= 1'b0;
      offline <= 1'b0;
      wchar <= 1'b0;
      ma_ok <= 1'b0;
      repeat (5) @(posedge ref_clk);
      rd(2'h2, 16'hff7f, 16'h804a);
      acc(1'b0, 2'h2, 16'h0000);
      boot(1'b1);
      rd(2'h2, 16'hffbf, 16'h840e);
      acc(1'b0, 2'h1, 16'h0000);
      bit_chk("start", cmd_start, 1'b0);
      acc(1'b0, 2'h2, 16'h0000);
      boot(1'b0);
      ext_feat <= 1'b0;
      i_host.ext_load(4'h5);
      acc(1'b0, 2'h1, 16'h0000);
      chk("pointer", cmd_ptr, 22'h000000);
      tc <= 3'h0;
      wchar <= 1'b1;
      exc <= 1'b1;
      @(posedge ref_clk);
      done <= 1'b1;
      @(posedge ref_clk);
      {done, wchar, exc} <= 3'h0;
      rd(2'h2, 16'hffff, 16'h8480);
      $display("test completion done");
   endtask
   task automatic t_dma();
      @(posedge ref_clk);
      dma_addr <= 22'h03abcd;
      addr_valid <= 1'b1;
      @(posedge ref_clk);
      addr_valid <= 1'b0;
      rd(2'h0, 16'hffff, 16'habcd);
      rd(2'h2, 16'h0300, 16'h0300);
      @(posedge ref_clk);
      ram_fail <= 1'b1;
      @(posedge ref_clk);
      ram_fail <= 1'b0;
      dma_req <= 1'b1;
      #1;
      bit_chk("store inhibit", inhibit, 1'b1);
      n = 0;
      while (n < 300 && dma_abort !== 1'b1) begin
         @(posedge ref_clk);
         #1;
         n++;
      end
      bit_chk("abort delay", n >= 190 && n <= 210, 1'b1);
      if (n == 300) begin
         give_verdict();
      end
      @(posedge ref_clk);
      dma_req <= 1'b0;
      rd(2'h2, 16'ha800, 16'ha800);
      $display("test dma done");
   endtask
   initial begin
      {rst, bus_init, offline, diag_pass, diag_fail, ram_fail, addr_valid, dma_req} = '0;
      {dma_reply, done, wchar, ma_ok, exc} = '0;
      ext_feat = 1'b1;
      tc = 3'h0;
      dma_addr = 22'h0;
      rst = 1'b1;
      repeat (2) @(posedge ref_clk);
      rst <= 1'b0;
      t_pointer();
      t_refused();
      t_complete();
      t_dma();
      give_verdict();
   end
endmodule
